// *** rtl/rgd_map_top.sv ***
// host address to dram row/effective address map with ecc error address log
// assumes one clock, synchronous reset, a single AXI4-Lite master, same-clock requesters
`timescale 1ns/10ps
module rgd_map_top #(
  parameter int NUM_ROWS = 8,
  parameter int LIMIT_W = 11
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [rgd_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [rgd_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic map_req_valid_in,
  input wire logic [35:0] map_req_addr_in,
  output logic map_valid_out,
  output logic map_hit_out,
  output logic [2:0] map_row_out,
  output logic [35:0] map_eff_addr_out,
  input wire logic ecc_ce_in,
  input wire logic ecc_ue_in,
  input wire logic [31:3] ecc_addr_in,
  input wire logic [1:0] ecc_qword_in,
  input wire logic ecc_upper_in,
  output logic [1:0] org_mode_out
);

  logic aw_held_r, w_held_r, bvalid_r, rvalid_r, wr_go, wr_hit, rd_hit_c;
  logic [rgd_pkg::IDX_W-1:0] wr_idx_r, rd_idx;
  logic [31:0] wdata_r, rdata_r, rd_data_c;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [LIMIT_W-1:0] row_lim_r [NUM_ROWS];
  logic [31:0] mg_ctrl_r, mg_upper_r, lg_ctrl_r, hg_start_r, hg_end_r, irq_range_r, mem_cfg_r, err_cmd_r;
  logic [31:0] ce_addr_r, ue_addr_r;
  logic ce_valid_r, ue_valid_r, ce_clr, ue_clr, cfg_bad_c;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign s_axi_awready_out = !aw_held_r && !bvalid_r;
  assign s_axi_wready_out = !w_held_r && !bvalid_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = !rvalid_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rdata_out = rdata_r;
  assign s_axi_rresp_out = rresp_r;
  assign rd_idx = s_axi_araddr_in[rgd_pkg::AXI_ADDR_W-1:2];
  assign org_mode_out = mem_cfg_r[rgd_pkg::CFG_ORG_LSB +: 2];

  // write channel: address and data taken independently, one write in flight
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_idx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= rgd_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_held_r <= 1'b1;
        wr_idx_r <= s_axi_awaddr_in[rgd_pkg::AXI_ADDR_W-1:2];
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata_in;
        wstrb_r <= s_axi_wstrb_in;
      end
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? rgd_pkg::RESP_OKAY : rgd_pkg::RESP_DECERR;
      end
      else if (bvalid_r && s_axi_bready_in)
        bvalid_r <= 1'b0;
    end
  end
  always_comb
  begin
    wr_hit = 1'b0;
    case (wr_idx_r)
      rgd_pkg::IDX_CE_ADDR, rgd_pkg::IDX_MG_CTRL, rgd_pkg::IDX_MG_UPPER, rgd_pkg::IDX_LG_CTRL,
      rgd_pkg::IDX_HG_START, rgd_pkg::IDX_HG_END, rgd_pkg::IDX_IRQ_RANGE, rgd_pkg::IDX_UE_ADDR,
      rgd_pkg::IDX_MEM_CFG, rgd_pkg::IDX_ERR_CMD, rgd_pkg::IDX_ERR_STS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_ROWS; i++)
    begin
      if (wr_idx_r == rgd_pkg::IDX_ROW_LIMIT_0 + rgd_pkg::IDX_ROW_STEP * (rgd_pkg::IDX_W)'(i))
        wr_hit = 1'b1;
    end
  end
  // row limits: only the limit field is stored, upper bits read as zero
  always_ff @(posedge clk_in)
  begin
    for (int i = 0; i < NUM_ROWS; i++)
    begin
      if (srst_in)
        row_lim_r[i] <= LIMIT_W'(rgd_pkg::RST_ROW_LIMIT);
      else if (wr_go && wr_idx_r == rgd_pkg::IDX_ROW_LIMIT_0 + rgd_pkg::IDX_ROW_STEP * (rgd_pkg::IDX_W)'(i))
        row_lim_r[i] <= LIMIT_W'(rgd_pkg::strb_merge(32'(row_lim_r[i]), wdata_r, wstrb_r));
    end
  end
  // gap, range and mode registers; reserved bits are masked off on write
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mg_ctrl_r <= rgd_pkg::RST_MG_CTRL;
      mg_upper_r <= rgd_pkg::RST_ZERO;
      lg_ctrl_r <= rgd_pkg::RST_LG_CTRL;
      hg_start_r <= rgd_pkg::RST_ZERO;
      hg_end_r <= rgd_pkg::RST_ZERO;
      irq_range_r <= rgd_pkg::RST_IRQ_RANGE;
      mem_cfg_r <= rgd_pkg::RST_MEM_CFG;
      err_cmd_r <= rgd_pkg::RST_ZERO;
    end
    else if (wr_go)
    begin
      case (wr_idx_r)
        rgd_pkg::IDX_MG_CTRL:
          mg_ctrl_r <= rgd_pkg::strb_merge(mg_ctrl_r, wdata_r, wstrb_r) & rgd_pkg::MSK_MG_CTRL;
        rgd_pkg::IDX_MG_UPPER:
          mg_upper_r <= rgd_pkg::strb_merge(mg_upper_r, wdata_r, wstrb_r) & rgd_pkg::MSK_MG_UPPER;
        rgd_pkg::IDX_LG_CTRL:
          lg_ctrl_r <= rgd_pkg::strb_merge(lg_ctrl_r, wdata_r, wstrb_r) & rgd_pkg::MSK_LG_CTRL;
        rgd_pkg::IDX_HG_START:
          hg_start_r <= rgd_pkg::strb_merge(hg_start_r, wdata_r, wstrb_r) & rgd_pkg::MSK_HG_START;
        rgd_pkg::IDX_HG_END:
          hg_end_r <= rgd_pkg::strb_merge(hg_end_r, wdata_r, wstrb_r) & rgd_pkg::MSK_HG_END;
        rgd_pkg::IDX_IRQ_RANGE:
          irq_range_r <= rgd_pkg::strb_merge(irq_range_r, wdata_r, wstrb_r) & rgd_pkg::MSK_IRQ_RANGE;
        rgd_pkg::IDX_MEM_CFG:
          mem_cfg_r <= rgd_pkg::strb_merge(mem_cfg_r, wdata_r, wstrb_r) & rgd_pkg::MSK_MEM_CFG;
        rgd_pkg::IDX_ERR_CMD:
          err_cmd_r <= rgd_pkg::strb_merge(err_cmd_r, wdata_r, wstrb_r) & rgd_pkg::MSK_ERR_CMD;
      endcase
    end
  end
  // status bits clear on write of one; only byte lane 0 holds them
  assign ce_clr = wr_go && wr_idx_r == rgd_pkg::IDX_ERR_STS && wstrb_r[0] && wdata_r[rgd_pkg::STS_CE_BIT];
  assign ue_clr = wr_go && wr_idx_r == rgd_pkg::IDX_ERR_STS && wstrb_r[0] && wdata_r[rgd_pkg::STS_UE_BIT];

  // first-error capture; an error in the clearing cycle is kept, not lost
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ce_valid_r <= 1'b0;
      ce_addr_r <= rgd_pkg::RST_ZERO;
    end
    else
    begin
      ce_valid_r <= (ce_valid_r && !ce_clr) || ecc_ce_in;
      if (ecc_ce_in && (!ce_valid_r || ce_clr))
      begin
        ce_addr_r <= {ecc_addr_in, ecc_qword_in,
                      ecc_upper_in && err_cmd_r[rgd_pkg::CMD_SBC_EN_BIT]};
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ue_valid_r <= 1'b0;
      ue_addr_r <= rgd_pkg::RST_ZERO;
    end
    else
    begin
      ue_valid_r <= (ue_valid_r && !ue_clr) || ecc_ue_in;
      if (ecc_ue_in && (!ue_valid_r || ue_clr))
      begin
        ue_addr_r <= {ecc_addr_in, ecc_qword_in, 1'b0};
      end
    end
  end

  // live check of programmed row sizes against the interleave mode
  always_comb
  begin
    logic [11:0] lo;
    logic [11:0] hi;
    logic [11:0] prev;
    logic [11:0] cur;
    lo = rgd_pkg::ROW_MIN_NONE;
    hi = rgd_pkg::ROW_MAX_NONE;
    prev = '0;
    cur = '0;
    cfg_bad_c = 1'b0;
    unique case (rgd_pkg::rgd_org_type'(mem_cfg_r[rgd_pkg::CFG_ORG_LSB +: 2]))
      rgd_pkg::ORG_NONE:
      begin
        lo = rgd_pkg::ROW_MIN_NONE;
        hi = rgd_pkg::ROW_MAX_NONE;
      end
      rgd_pkg::ORG_2WAY:
      begin
        lo = rgd_pkg::ROW_MIN_2WAY;
        hi = rgd_pkg::ROW_MAX_2WAY;
      end
      rgd_pkg::ORG_4WAY:
      begin
        lo = rgd_pkg::ROW_MIN_4WAY;
        hi = rgd_pkg::ROW_MAX_4WAY;
      end
      rgd_pkg::ORG_RSVD:
        cfg_bad_c = 1'b1;
    endcase
    for (int i = 0; i < NUM_ROWS; i++)
    begin
      cur = 12'(row_lim_r[i]);
      if (cur < prev || (cur != prev && (cur - prev < lo || cur - prev > hi)))
        cfg_bad_c = 1'b1;
      prev = cur;
    end
  end
  always_comb
  begin
    rd_hit_c = 1'b1;
    rd_data_c = '0;
    case (rd_idx)
      rgd_pkg::IDX_CE_ADDR: rd_data_c = ce_addr_r;
      rgd_pkg::IDX_MG_CTRL: rd_data_c = mg_ctrl_r;
      rgd_pkg::IDX_MG_UPPER: rd_data_c = mg_upper_r;
      rgd_pkg::IDX_LG_CTRL: rd_data_c = lg_ctrl_r;
      rgd_pkg::IDX_HG_START: rd_data_c = hg_start_r;
      rgd_pkg::IDX_HG_END: rd_data_c = hg_end_r;
      rgd_pkg::IDX_IRQ_RANGE: rd_data_c = irq_range_r;
      rgd_pkg::IDX_UE_ADDR: rd_data_c = ue_addr_r;
      rgd_pkg::IDX_MEM_CFG: rd_data_c = mem_cfg_r;
      rgd_pkg::IDX_ERR_CMD: rd_data_c = err_cmd_r;
      rgd_pkg::IDX_ERR_STS:
      begin
        rd_data_c[rgd_pkg::STS_CE_BIT] = ce_valid_r;
        rd_data_c[rgd_pkg::STS_UE_BIT] = ue_valid_r;
        rd_data_c[rgd_pkg::STS_CFG_BIT] = cfg_bad_c;
      end
      default: rd_hit_c = 1'b0;
    endcase
    for (int i = 0; i < NUM_ROWS; i++)
    begin
      if (rd_idx == rgd_pkg::IDX_ROW_LIMIT_0 + rgd_pkg::IDX_ROW_STEP * (rgd_pkg::IDX_W)'(i))
      begin
        rd_hit_c = 1'b1;
        rd_data_c = 32'(row_lim_r[i]);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= rgd_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_in && s_axi_arready_out)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data_c;
      rresp_r <= rd_hit_c ? rgd_pkg::RESP_OKAY : rgd_pkg::RESP_DECERR;
    end
    else if (rvalid_r && s_axi_rready_in)
      rvalid_r <= 1'b0;
  end
  // address map, gaps in 1 MB units; gaps never wrap since gap ends are kept 17 bits wide
  logic [15:0] req_mb, eff_mb_c;
  logic [16:0] lg_lo, lg_hi, mg_lo, mg_hi, hg_lo, hg_hi, sub_mb_c;
  logic in_gap_c, irq_hit_c, row_found_c;
  logic [2:0] row_c;
  assign req_mb = map_req_addr_in[35:20];
  assign lg_lo = {5'h00, lg_ctrl_r[rgd_pkg::LG_START_LSB +: 12]};
  assign lg_hi = lg_lo + 17'(rgd_pkg::gap_mb(lg_ctrl_r[rgd_pkg::LG_SIZE_LSB +: 5]));
  assign mg_lo = {1'b0, mg_upper_r[11:0], mg_ctrl_r[rgd_pkg::MG_START_LSB +: 4]};
  assign mg_hi = mg_lo + 17'(rgd_pkg::gap_mb(mg_ctrl_r[rgd_pkg::MG_SIZE_LSB +: 5]));
  assign hg_lo = {1'b0, hg_start_r[15:0]};
  assign hg_hi = {1'b0, hg_end_r[15:0]} + 17'h00001;

  always_comb
  begin
    logic lg_on;
    logic mg_on;
    logic hg_on;
    lg_on = lg_ctrl_r[rgd_pkg::LG_EN_BIT];
    mg_on = mg_ctrl_r[rgd_pkg::MG_EN_BIT];
    hg_on = hg_start_r[rgd_pkg::HG_EN_BIT];
    in_gap_c = (lg_on && 17'(req_mb) >= lg_lo && 17'(req_mb) < lg_hi) ||
               (mg_on && 17'(req_mb) >= mg_lo && 17'(req_mb) < mg_hi) ||
               (hg_on && 17'(req_mb) >= hg_lo && 17'(req_mb) < hg_hi);
    sub_mb_c = '0;
    // reclaim closes the hole so the dram under it is reached from above
    if (lg_on && lg_ctrl_r[rgd_pkg::LG_RECLAIM_BIT] && 17'(req_mb) >= lg_hi)
      sub_mb_c = sub_mb_c + (lg_hi - lg_lo);
    if (mg_on && mg_ctrl_r[rgd_pkg::MG_RECLAIM_BIT] && 17'(req_mb) >= mg_hi)
      sub_mb_c = sub_mb_c + (mg_hi - mg_lo);
    if (hg_on && 17'(req_mb) >= hg_hi && hg_hi > hg_lo)
      sub_mb_c = sub_mb_c + (hg_hi - hg_lo);
    eff_mb_c = req_mb - sub_mb_c[15:0];
    irq_hit_c = irq_range_r[rgd_pkg::IRQ_EN_BIT] &&
                map_req_addr_in[35:16] == {irq_range_r[rgd_pkg::IRQ_BASE_LSB +: 16], 4'h0};
  end

  always_comb
  begin
    row_found_c = 1'b0;
    row_c = '0;
    for (int i = NUM_ROWS - 1; i >= 0; i--)
    begin
      if (14'(row_lim_r[i]) > eff_mb_c[15:2])
      begin
        row_found_c = 1'b1;
        row_c = 3'(i);
      end
    end
  end
  // one-cycle registered map answer
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      map_valid_out <= 1'b0;
      map_hit_out <= 1'b0;
      map_row_out <= '0;
      map_eff_addr_out <= '0;
    end
    else
    begin
      map_valid_out <= map_req_valid_in;
      map_hit_out <= map_req_valid_in && !in_gap_c && !irq_hit_c && row_found_c;
      map_row_out <= row_c;
      map_eff_addr_out <= {eff_mb_c, map_req_addr_in[19:0]};
    end
  end

endmodule

// *** rtl/rgd_pkg.sv ***
// constants, field positions and helpers for the dram row/gap decode and error log
// assumes a 25 MHz system clock and a 32-bit AXI4-Lite register port
// Function
// - row limits are 11-bit registers holding cumulative tops in 4 MB units
// - rows are compared against the effective address with reclaimed gaps and the high gap removed
// - row size is limit minus previous limit; field 6:0 or 10:0
// - every row limit resets to one 4 MB unit
// - first correctable error latches effective address bits 31:3
// - bits 2:1 hold transfer-order qword index, 00 for single qword
// - bit 0 flags upper dword, only while correction is enabled
// - first uncorrectable error latches address 31:3 and qword index
// - mid gap enable bit 15, size code bits 14:10 decode table
// - mid gap start from control 7:4 and upper register 11:0
// - reclaim bits 9 and 10 make dram behind a gap reachable
// - low gap start bits 31:20, enable bit 11, size bits 4:0
// - high gap enable bit 31, start/end 15:0 in MB, end inclusive
// - enabled 64 KB interrupt-controller range is not claimed
// - organisation bits 4:3 select non, 2-way or 4-way interleave
package rgd_pkg;
  localparam int AXI_ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_ROW_LIMIT_0 = 10'h060;
  localparam logic [IDX_W-1:0] IDX_ROW_STEP = 10'h002;
  localparam logic [IDX_W-1:0] IDX_CE_ADDR = 10'h074;
  localparam logic [IDX_W-1:0] IDX_MG_CTRL = 10'h078;
  localparam logic [IDX_W-1:0] IDX_MG_UPPER = 10'h07a;
  localparam logic [IDX_W-1:0] IDX_LG_CTRL = 10'h07c;
  localparam logic [IDX_W-1:0] IDX_HG_START = 10'h088;
  localparam logic [IDX_W-1:0] IDX_HG_END = 10'h08c;
  localparam logic [IDX_W-1:0] IDX_IRQ_RANGE = 10'h0a4;
  localparam logic [IDX_W-1:0] IDX_UE_ADDR = 10'h0a8;
  localparam logic [IDX_W-1:0] IDX_MEM_CFG = 10'h050;
  localparam logic [IDX_W-1:0] IDX_ERR_CMD = 10'h0c0;
  localparam logic [IDX_W-1:0] IDX_ERR_STS = 10'h0c2;

  localparam logic [31:0] RST_ROW_LIMIT = 32'h0000_0001;
  localparam logic [31:0] RST_MG_CTRL = 32'h0000_0010;
  localparam logic [31:0] RST_LG_CTRL = 32'h0010_0000;
  localparam logic [31:0] RST_IRQ_RANGE = 32'h00fe_c001;
  localparam logic [31:0] RST_MEM_CFG = 32'h0000_0008;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  localparam logic [31:0] MSK_MG_CTRL = 32'h0000_fef0;
  localparam logic [31:0] MSK_MG_UPPER = 32'h0000_0fff;
  localparam logic [31:0] MSK_LG_CTRL = 32'hfff0_0c1f;
  localparam logic [31:0] MSK_HG_START = 32'h8000_ffff;
  localparam logic [31:0] MSK_HG_END = 32'h0000_ffff;
  localparam logic [31:0] MSK_IRQ_RANGE = 32'h0fff_f001;
  localparam logic [31:0] MSK_MEM_CFG = 32'h0000_0018;
  localparam logic [31:0] MSK_ERR_CMD = 32'h0000_0004;

  localparam int MG_EN_BIT = 15;
  localparam int MG_RECLAIM_BIT = 9;
  localparam int MG_SIZE_LSB = 10;
  localparam int MG_START_LSB = 4;
  localparam int LG_EN_BIT = 11;
  localparam int LG_RECLAIM_BIT = 10;
  localparam int LG_SIZE_LSB = 0;
  localparam int LG_START_LSB = 20;
  localparam int HG_EN_BIT = 31;
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_BASE_LSB = 12;
  localparam int CFG_ORG_LSB = 3;
  localparam int CMD_SBC_EN_BIT = 2;
  localparam int STS_CE_BIT = 0;
  localparam int STS_UE_BIT = 1;
  localparam int STS_CFG_BIT = 2;

  typedef enum logic [1:0] {
    ORG_RSVD = 2'b00,
    ORG_NONE = 2'b01,
    ORG_2WAY = 2'b10,
    ORG_4WAY = 2'b11
  } rgd_org_type;

  // row size bounds in 4 MB units
  localparam logic [11:0] ROW_MIN_NONE = 12'h001;
  localparam logic [11:0] ROW_MAX_NONE = 12'h020;
  localparam logic [11:0] ROW_MIN_2WAY = 12'h002;
  localparam logic [11:0] ROW_MAX_2WAY = 12'h040;
  localparam logic [11:0] ROW_MIN_4WAY = 12'h004;
  localparam logic [11:0] ROW_MAX_4WAY = 12'h080;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // reserved size codes give zero, so such a gap hides nothing
  function automatic logic [5:0] gap_mb(input logic [4:0] code);
    case (code)
      5'h00: gap_mb = 6'h01;
      5'h04: gap_mb = 6'h02;
      5'h0c: gap_mb = 6'h04;
      5'h1c: gap_mb = 6'h08;
      5'h1e: gap_mb = 6'h10;
      5'h1f: gap_mb = 6'h20;
      default: gap_mb = 6'h00;
    endcase
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    for (int b = 0; b < 4; b++)
    begin
      strb_merge[b*8 +: 8] = strb[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];
    end
  endfunction
endpackage

// *** test/rgd_map_checker.sv ***
// assertions on the map, register-bus and config ports of rgd_map_top
// assumes it is bound into the top with all ports by name, one clock
`timescale 1ns/10ps
module rgd_map_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic map_req_valid_in,
  input wire logic map_valid_out,
  input wire logic map_hit_out,
  input wire logic [1:0] org_mode_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  AST_MAP_ANSWER: assert property (map_req_valid_in |=> map_valid_out)
    else $error("map request not answered one cycle later");
  AST_MAP_QUIET: assert property (!map_req_valid_in |=> !map_valid_out)
    else $error("map answer without a request");
  AST_ORG_RESET: assert property ($past(srst_in) |-> org_mode_out == 2'b01)
    else $error("organisation not non-interleaved after reset");
  AST_WR_ANSWER: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##2 s_axi_bvalid_out)
    else $error("write response late");
  AST_B_STAND: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped or changed");
  AST_RD_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read data late");
  AST_R_STAND: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped or changed");
  AST_R_BLOCK: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
    else $error("read data not retired after its handshake");
  COV_HIT: cover property (map_valid_out && map_hit_out);
  COV_MISS: cover property (map_valid_out && !map_hit_out);
  COV_DECERR: cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h3);
endmodule

// *** test/rgd_dram_model.sv ***
// far side: dram read path reporting ecc errors of a transfer
// assumes the bench gives a one-cycle fire code per error
`timescale 1ns/10ps
module rgd_dram_model (
  input wire logic clk_in,
  input wire logic [1:0] fire_in,
  input wire logic [31:3] addr_in,
  input wire logic [1:0] qword_in,
  input wire logic upper_in,
  output logic ecc_ce_out = 1'b0,
  output logic ecc_ue_out = 1'b0,
  output logic [31:3] ecc_addr_out = 29'h0,
  output logic [1:0] ecc_qword_out = 2'h0,
  output logic ecc_upper_out = 1'b0
);
  always @(posedge clk_in)
  begin
    ecc_ce_out <= fire_in[0];
    ecc_ue_out <= fire_in[1];
    // lines drift between reports so a stale value never looks valid
    if (fire_in != 2'h0)
      {ecc_addr_out, ecc_qword_out, ecc_upper_out} <= {addr_in, qword_in, upper_in};
    else
      {ecc_addr_out, ecc_qword_out, ecc_upper_out} <= ~{ecc_addr_out, ecc_qword_out, ecc_upper_out};
  end
endmodule

// *** test/tb_top.sv ***
// self-checking bench for rgd_map_top: registers, row/gap map, ecc log
// assumes the rtl package and top compiled first, dram model beside it
`timescale 1ns/10ps
module tb_top;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
  logic [31:0] s_axi_wdata_in = 32'h0;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, map_req_valid_in = 1'b0;
  logic [35:0] map_req_addr_in = 36'h0;
  logic ecc_ce_in, ecc_ue_in, ecc_upper_in, map_valid_out, map_hit_out;
  logic [31:3] ecc_addr_in;
  logic [1:0] ecc_qword_in, s_axi_bresp_out, s_axi_rresp_out, org_mode_out;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [31:0] s_axi_rdata_out;
  logic [2:0] map_row_out;
  logic [35:0] map_eff_addr_out;
  logic [1:0] fire = 2'h0, fq = 2'h0;
  logic fu = 1'b0;
  logic [31:3] fa = 29'h0;
  int err_count = 0, checks = 0, cyc = 0;
  logic [4:0] codes [6] = '{5'h00, 5'h04, 5'h0c, 5'h1c, 5'h1e, 5'h1f};
  logic [41:0] rst_tab [9] = '{{rgd_pkg::IDX_MG_CTRL, 32'h10}, {rgd_pkg::IDX_MG_UPPER, 32'h0},
    {rgd_pkg::IDX_LG_CTRL, 32'h00100000}, {rgd_pkg::IDX_HG_START, 32'h0}, {rgd_pkg::IDX_HG_END, 32'h0},
    {rgd_pkg::IDX_IRQ_RANGE, 32'h00fec001}, {rgd_pkg::IDX_CE_ADDR, 32'h0}, {rgd_pkg::IDX_UE_ADDR, 32'h0},
    {rgd_pkg::IDX_MEM_CFG, 32'h8}};
  // address, hit, row, effective address
  logic [75:0] cases [5] = '{{36'h0, 1'b1, 3'h0, 36'h0}, {36'hfffff8, 1'b1, 3'h0, 36'hfffff8},
    {36'h1000000, 1'b1, 3'h2, 36'h1000000}, {36'h7fffff8, 1'b1, 3'h2, 36'h7fffff8},
    {36'h8000000, 1'b0, 3'h0, 36'h0}};

  rgd_map_top DUT (.*);
  rgd_dram_model u_dram (.clk_in(clk_in), .fire_in(fire), .addr_in(fa), .qword_in(fq), .upper_in(fu),
    .ecc_ce_out(ecc_ce_in), .ecc_ue_out(ecc_ue_in), .ecc_addr_out(ecc_addr_in), .ecc_qword_out(ecc_qword_in),
    .ecc_upper_out(ecc_upper_in));

  always #20 clk_in = ~clk_in;

  task conclude;
  begin
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      $display("MISMATCH run_length expected 6000 seen 6000");
      conclude;
    end
  end

  task chk(input string what, input logic [35:0] exp, input logic [35:0] got);
  begin
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, a, w;
  begin
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_in);
    s_axi_awaddr_in <= {idx, 2'b00};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wdata_in <= d;
    s_axi_wvalid_in <= 1'b1;
    do
    begin
      @(negedge clk_in);
      a = pa && s_axi_awready_out;
      w = pw && s_axi_wready_out;
      @(posedge clk_in);
      if (a)
        pa = 1'b0;
      if (w)
        pw = 1'b0;
      s_axi_awvalid_in <= pa;
      s_axi_wvalid_in <= pw;
    end
    while (pa || pw);
    do
      @(negedge clk_in);
    while (!s_axi_bvalid_out);
    chk("bresp", er, s_axi_bresp_out);
    @(posedge clk_in);
    s_axi_bready_in <= 1'b1;
    @(posedge clk_in);
    s_axi_bready_in <= 1'b0;
  end
  endtask

  task rd(input logic [9:0] idx, input logic [31:0] exp, input logic [31:0] msk, input logic [1:0] er);
    logic a;
  begin
    @(posedge clk_in);
    s_axi_araddr_in <= {idx, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    do
    begin
      @(negedge clk_in);
      a = s_axi_arready_out;
      @(posedge clk_in);
    end
    while (!a);
    s_axi_arvalid_in <= 1'b0;
    do
      @(negedge clk_in);
    while (!s_axi_rvalid_out);
    chk("rdata", exp, s_axi_rdata_out & msk);
    chk("rresp", er, s_axi_rresp_out);
    @(posedge clk_in);
    s_axi_rready_in <= 1'b1;
    @(posedge clk_in);
    s_axi_rready_in <= 1'b0;
  end
  endtask

  task mp(input logic [35:0] a, input logic h, input logic [2:0] r, input logic [35:0] e);
  begin
    @(posedge clk_in);
    map_req_valid_in <= 1'b1;
    map_req_addr_in <= a;
    @(posedge clk_in);
    map_req_valid_in <= 1'b0;
    map_req_addr_in <= ~a;
    @(negedge clk_in);
    chk("map_valid", 36'h1, {35'h0, map_valid_out});
    chk("map_hit", {35'h0, h}, {35'h0, map_hit_out});
    if (h)
    begin
      chk("map_row", {33'h0, r}, {33'h0, map_row_out});
      chk("map_eff", e, map_eff_addr_out);
    end
  end
  endtask

  task er(input logic [1:0] k, input logic [31:3] a, input logic [1:0] q, input logic u);
  begin
    @(posedge clk_in);
    fire <= k;
    fa <= a;
    fq <= q;
    fu <= u;
    @(posedge clk_in);
    fire <= 2'h0;
    @(posedge clk_in);
  end
  endtask

  task rst_chk;
  begin
    for (int r = 0; r < 8; r++)
      rd(rgd_pkg::IDX_ROW_LIMIT_0 + 10'(2 * r), 32'h1, 32'hffffffff, 2'h0);
    for (int i = 0; i < 9; i++)
      rd(rst_tab[i][41:32], rst_tab[i][31:0], 32'hffffffff, 2'h0);
  end
  endtask

  initial
  begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rst_chk;
    wr(rgd_pkg::IDX_ROW_LIMIT_0, 32'hffffffff, 2'h0);
    rd(rgd_pkg::IDX_ROW_LIMIT_0, 32'h7ff, 32'hffffffff, 2'h0);
    rd(rgd_pkg::IDX_ERR_STS, 32'h4, 32'h4, 2'h0);
    wr(rgd_pkg::IDX_CE_ADDR, 32'hffffffff, 2'h0);
    rd(rgd_pkg::IDX_CE_ADDR, 32'h0, 32'hffffffff, 2'h0);
    wr(10'h3ff, 32'h1, 2'h3);
    rd(10'h3ff, 32'h0, 32'hffffffff, 2'h3);
    for (int m = 3; m > 0; m--)
    begin
      wr(rgd_pkg::IDX_MEM_CFG, 32'(m) << 3, 2'h0);
      chk("org_mode", 36'(m), {34'h0, org_mode_out});
    end
    $display("done registers");
    for (int r = 0; r < 8; r++)
      wr(rgd_pkg::IDX_ROW_LIMIT_0 + 10'(2 * r), (r < 2) ? 32'h4 : 32'h20, 2'h0);
    for (int i = 0; i < 5; i++)
      mp(cases[i][75:40], cases[i][39], cases[i][38:36], cases[i][35:0]);
    $display("done rows");
    wr(rgd_pkg::IDX_IRQ_RANGE, 32'h00010001, 2'h0);
    mp(36'h1000000, 1'b0, 3'h0, 36'h0);
    mp(36'h100fff8, 1'b0, 3'h0, 36'h0);
    mp(36'h1010000, 1'b1, 3'h2, 36'h1010000);
    wr(rgd_pkg::IDX_IRQ_RANGE, 32'h00010000, 2'h0);
    mp(36'h1000000, 1'b1, 3'h2, 36'h1000000);
    $display("done irq range");
    for (int k = 0; k < 6; k++)
    begin
      wr(rgd_pkg::IDX_LG_CTRL, 32'h00800c00 | 32'(codes[k]), 2'h0);
      mp(36'h800000 + (36'h100000 << k) - 36'h8, 1'b0, 3'h0, 36'h0);
      mp(36'h800000 + (36'h100000 << k), 1'b1, 3'h0, 36'h800000);
    end
    wr(rgd_pkg::IDX_LG_CTRL, 32'h00800804, 2'h0);
    mp(36'h7ffff8, 1'b1, 3'h0, 36'h7ffff8);
    mp(36'h800000, 1'b0, 3'h0, 36'h0);
    mp(36'ha00000, 1'b1, 3'h0, 36'ha00000);
    wr(rgd_pkg::IDX_LG_CTRL, 32'h00100000, 2'h0);
    wr(rgd_pkg::IDX_MG_UPPER, 32'h2, 2'h0);
    wr(rgd_pkg::IDX_MG_CTRL, 32'hfe10, 2'h0);
    mp(36'h20ffff8, 1'b1, 3'h2, 36'h20ffff8);
    mp(36'h2100000, 1'b0, 3'h0, 36'h0);
    mp(36'h40ffff8, 1'b0, 3'h0, 36'h0);
    mp(36'h4100000, 1'b1, 3'h2, 36'h2100000);
    wr(rgd_pkg::IDX_HG_START, 32'h80000050, 2'h0);
    wr(rgd_pkg::IDX_HG_END, 32'h5f, 2'h0);
    mp(36'h4fffff8, 1'b1, 3'h2, 36'h2fffff8);
    mp(36'h5000000, 1'b0, 3'h0, 36'h0);
    mp(36'h5fffff8, 1'b0, 3'h0, 36'h0);
    mp(36'h6000000, 1'b1, 3'h2, 36'h3000000);
    $display("done gaps");
    wr(rgd_pkg::IDX_ERR_CMD, 32'h4, 2'h0);
    er(2'h1, 29'h01234567, 2'h2, 1'b1);
    rd(rgd_pkg::IDX_CE_ADDR, {29'h01234567, 3'h5}, 32'hffffffff, 2'h0);
    rd(rgd_pkg::IDX_ERR_STS, 32'h1, 32'h3, 2'h0);
    er(2'h1, 29'h17654321, 2'h1, 1'b0);
    rd(rgd_pkg::IDX_CE_ADDR, {29'h01234567, 3'h5}, 32'hffffffff, 2'h0);
    wr(rgd_pkg::IDX_ERR_STS, 32'h1, 2'h0);
    rd(rgd_pkg::IDX_ERR_STS, 32'h0, 32'h3, 2'h0);
    wr(rgd_pkg::IDX_ERR_CMD, 32'h0, 2'h0);
    er(2'h1, 29'h17654321, 2'h3, 1'b1);
    rd(rgd_pkg::IDX_CE_ADDR, {29'h17654321, 3'h6}, 32'hffffffff, 2'h0);
    er(2'h2, 29'h01234567, 2'h3, 1'b1);
    rd(rgd_pkg::IDX_UE_ADDR, {29'h01234567, 3'h6}, 32'hffffffff, 2'h0);
    er(2'h2, 29'h17654321, 2'h0, 1'b0);
    rd(rgd_pkg::IDX_UE_ADDR, {29'h01234567, 3'h6}, 32'hffffffff, 2'h0);
    rd(rgd_pkg::IDX_ERR_STS, 32'h3, 32'h7, 2'h0);
    $display("done error log");
    @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rst_chk;
    mp(36'h3ffff8, 1'b1, 3'h0, 36'h3ffff8);
    mp(36'h400000, 1'b0, 3'h0, 36'h0);
    $display("done second reset");
    conclude;
  end
endmodule

bind rgd_map_top rgd_map_checker u_chk (.*);
